/* design/pmis_i2c_slave.sv */
/*
 * Two-wire slave port with the first interrupt status register and its mask.
 * Assumes open-drain SDA resolved outside, SCL input only (no stretching),
 * status sources and undervoltage level arriving from other domains.
 */
`timescale 1ns/1ps
module pmis_i2c_slave (
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    input  wire logic              i_uvlo,
    input  wire logic [1:0]        i_addr_opt,
    input  wire pmis_pkg::pmis_src_t i_src,
    output logic                   o_sda_out,
    output logic                   o_sda_oe,
    output logic                   o_irq_n,
    output logic                   o_osc_en,
    output logic                   o_hs_mode
);
    import pmis_pkg::*;

    // ************************************************************
    // pin conditioning and condition detection
    // ************************************************************
    logic scl_f;
    logic sda_f;
    logic scl_d;
    logic sda_d;

    pmis_pin_filter u_scl_filter (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_pin     (i_scl),
        .o_level   (scl_f)
    );
    pmis_pin_filter u_sda_filter (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_pin     (i_sda),
        .o_level   (sda_f)
    );

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    wire scl_rise   = scl_f & ~scl_d;
    wire scl_fall   = ~scl_f & scl_d;
    wire start_cond = scl_f & scl_d & sda_d & ~sda_f;
    wire stop_cond  = scl_f & scl_d & ~sda_d & sda_f;

    // ************************************************************
    // undervoltage, strap and source synchronisers
    // ************************************************************
    logic      uvlo_meta;
    logic      hold;
    logic [1:0] strap_meta;
    logic [1:0] strap;
    pmis_src_t src_meta;
    pmis_src_t src_sync;
    logic [7:0] src_prev;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            uvlo_meta <= 1'b1;
            hold      <= 1'b1;
            src_meta  <= '0;
            src_sync  <= '0;
        end else begin
            uvlo_meta <= i_uvlo;
            hold      <= uvlo_meta;
            src_meta  <= i_src;
            src_sync  <= src_meta;
        end
    end

    // strap is static, so a plain two-flop path is enough
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            strap_meta <= 2'h0;
            strap      <= 2'h0;
        end else begin
            strap_meta <= i_addr_opt;
            strap      <= strap_meta;
        end
    end

    wire [6:0] own_addr = {OWN_ADDR_DEFAULT[6:2], strap};

    // ************************************************************
    // two-entry write buffer
    // ************************************************************
    pmis_wr_t   buf_mem [2];
    logic       buf_wp;
    logic       buf_rp;
    logic [1:0] buf_cnt;
    logic       push;
    pmis_wr_t   push_word;
    logic       tx_load;

    wire      buf_ready = (buf_cnt != 2'h2);
    wire      buf_valid = (buf_cnt != 2'h0);
    wire      drain_rdy = ~tx_load;  // read fetch owns the pointer this cycle
    wire      pop       = buf_valid & drain_rdy;
    pmis_wr_t head;
    assign head = buf_mem[buf_rp];

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            buf_wp  <= 1'b0;
            buf_rp  <= 1'b0;
            buf_cnt <= 2'h0;
        end else if (hold) begin
            buf_wp  <= 1'b0;
            buf_rp  <= 1'b0;
            buf_cnt <= 2'h0;
        end else begin
            buf_wp  <= buf_wp ^ push;
            buf_rp  <= buf_rp ^ pop;
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            buf_mem[buf_wp] <= push_word;
        end
    end

    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] ptr;
    logic [7:0] next_status;
    logic [7:0] next_ptr;

    wire        reg_wr    = pop & ~head.first;
    wire        wr_status = reg_wr & (ptr == REG_STATUS_ONE);
    wire        wr_mask   = reg_wr & (ptr == REG_MASK_ONE);
    wire        pend_clr  = wr_status & ~head.data[PEND_BIT];

    wire [7:0]  src8      = {src_sync, 1'b0};
    wire [7:0]  src_rise  = src8 & ~src_prev & STICKY_BITS;
    wire [7:0]  src_chg   = (src8 ^ src_prev) & LEVEL_BITS;
    wire        irq_evt   = |((src_rise | src_chg) & mask);

    wire [7:0]  rd_data   = (ptr == REG_STATUS_ONE) ? status :
                            (ptr == REG_MASK_ONE)   ? mask   :
                            READ_UNMAPPED;

    always_comb begin
        next_status = status;
        if (pend_clr) begin
            next_status = status & ~(STICKY_BITS | PEND_BIT_MASK);
        end
        // snapshot only on an interrupt; the event beats a same-cycle clear
        if (irq_evt) begin
            next_status = (next_status & STICKY_BITS) | (src8 & (STICKY_BITS | LEVEL_BITS))
                        | PEND_BIT_MASK;
        end
    end

    always_comb begin
        next_ptr = ptr;
        if (pop && head.first) begin
            next_ptr = head.data;
        end else if (pop || tx_load) begin
            next_ptr = ptr + 8'h01;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            status   <= STATUS_RESET;
            mask     <= MASK_RESET;
            ptr      <= PTR_RESET;
            src_prev <= 8'h00;
            o_irq_n  <= 1'b1;
        end else if (hold) begin
            status   <= STATUS_RESET;
            mask     <= MASK_RESET;
            ptr      <= PTR_RESET;
            src_prev <= src8;
            o_irq_n  <= 1'b1;
        end else begin
            status   <= next_status;
            mask     <= wr_mask ? (head.data & MASK_WRITABLE) : mask;
            ptr      <= next_ptr;
            src_prev <= src8;
            o_irq_n  <= ~next_status[PEND_BIT];
        end
    end

    // ************************************************************
    // bit engine
    // ************************************************************
    pmis_state_t state;
    pmis_state_t next_state;
    logic [3:0]  bitcnt;
    logic [3:0]  next_cnt;
    logic [7:0]  shreg;
    logic [7:0]  next_sh;
    logic        rw;
    logic        next_rw;
    logic        first_byte;
    logic        next_first;
    logic        next_oe;
    logic        next_hs;
    logic        next_busy;

    wire byte_done = scl_fall && (bitcnt == BITS_PER_BYTE);
    wire addr_hit  = (shreg[7:1] == own_addr);
    wire hs_code   = (shreg[7:3] == HS_CODE_TOP);

    assign push_word = '{first: first_byte, data: shreg};

    always_comb begin
        next_state = state;
        next_cnt   = bitcnt;
        next_sh    = shreg;
        next_rw    = rw;
        next_first = first_byte;
        next_oe    = o_sda_oe;
        next_hs    = o_hs_mode;
        next_busy  = o_osc_en;
        push       = 1'b0;
        tx_load    = 1'b0;
        if (stop_cond) begin
            next_state = ST_IDLE;
            next_oe    = 1'b0;
            next_hs    = 1'b0;
            next_busy  = 1'b0;
        end else if (start_cond) begin
            // repeated start keeps high-speed, plain start from idle too
            next_state = ST_ADDR;
            next_cnt   = 4'h0;
            next_oe    = 1'b0;
            next_busy  = 1'b1;
            next_first = 1'b1;
        end else begin
            unique case (state)
                ST_IDLE, ST_SKIP: begin
                    next_oe = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        next_sh  = {shreg[6:0], sda_f};
                        next_cnt = bitcnt + 4'h1;
                    end else if (byte_done && state == ST_ADDR) begin
                        if (addr_hit) begin
                            next_oe    = 1'b1;
                            next_rw    = shreg[0];
                            next_state = ST_ADDR_ACK;
                        end else begin
                            next_hs    = o_hs_mode | hs_code;
                            next_state = ST_SKIP;
                        end
                    end else if (byte_done) begin
                        // a full buffer refuses the byte with a not-acknowledge
                        if (buf_ready) begin
                            push       = 1'b1;
                            next_oe    = 1'b1;
                            next_state = ST_RX_ACK;
                        end else begin
                            next_state = ST_SKIP;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RX_ACK: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (state == ST_ADDR_ACK && rw) begin
                            tx_load    = 1'b1;
                            next_sh    = rd_data;
                            next_oe    = ~rd_data[7];
                            next_state = ST_TX;
                        end else begin
                            next_oe    = 1'b0;
                            next_first = (state == ST_ADDR_ACK);
                            next_state = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        next_cnt = bitcnt + 4'h1;
                    end else if (byte_done) begin
                        next_oe    = 1'b0;
                        next_state = ST_TX_ACK;
                    end else if (scl_fall) begin
                        next_sh = {shreg[6:0], 1'b0};
                        next_oe = ~shreg[6];
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise && sda_f) begin
                        next_state = ST_SKIP;
                    end else if (scl_fall) begin
                        next_cnt   = 4'h0;
                        tx_load    = 1'b1;
                        next_sh    = rd_data;
                        next_oe    = ~rd_data[7];
                        next_state = ST_TX;
                    end
                end
            endcase
        end
    end

    // slave-only engine; the master alone drives SCL
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state      <= ST_IDLE;
            bitcnt     <= 4'h0;
            shreg      <= 8'h00;
            rw         <= 1'b0;
            first_byte <= 1'b1;
            o_sda_oe   <= 1'b0;
            o_hs_mode  <= 1'b0;
            o_osc_en   <= 1'b0;
            o_sda_out  <= 1'b0;
        end else if (hold) begin
            state      <= ST_IDLE;
            bitcnt     <= 4'h0;
            shreg      <= 8'h00;
            rw         <= 1'b0;
            first_byte <= 1'b1;
            o_sda_oe   <= 1'b0;
            o_hs_mode  <= 1'b0;
            o_osc_en   <= 1'b0;
            o_sda_out  <= 1'b0;
        end else begin
            state      <= next_state;
            bitcnt     <= next_cnt;
            shreg      <= next_sh;
            rw         <= next_rw;
            first_byte <= next_first;
            o_sda_oe   <= next_oe;
            o_hs_mode  <= next_hs;
            o_osc_en   <= next_busy;
            o_sda_out  <= 1'b0;
        end
    end

endmodule

/* design/pmis_pkg.sv */
/*
 * Shared constants and types for the power-management two-wire slave port
 * and its first interrupt status register.
 * Assumes a 20 MHz system clock; link pins are open drain with pull-ups.
 */
// Contract
// - Slave only; standard, fast and high-speed rates are accepted.
// - Only 7-bit addresses decode; 10-bit and general call get no answer.
// - Address defaults to 1001000; two low bits come from a factory strap.
// - Registers stay at defaults during undervoltage and load after it ends.
// - Interface oscillator runs only while the bus addresses the port; here it runs from any START until STOP, whatever the address.
// - SDA falling while SCL high is a START.
// - SDA rising while SCL high is a STOP; the slave releases SDA.
// - SDA changes only while SCL low; stable through SCL high.
// - Acknowledge own address by holding SDA low through ninth clock high.
// - The receiver acknowledges each byte; byte sequences may run on.
// - After STOP, ignore traffic until START plus own address.
// - Reads of unmapped register addresses return FFh.
// - High-speed code 00001XXX is never acknowledged but enters high-speed.
// - After the code, a repeated START begins normal transfers at high speed.
// - STOP in high-speed operation returns to normal and fast rate.
// - Status bits 7 and 6 are converter overload flags, interrupt on rise.
// - Status bit 5 is charge done, interrupt on rise.
// - Bits 4 to 1 show charge, battery, system, adapter; interrupt on change.
// - Bit 0 is interrupt pending, read/write; all bits reset to 0.
// - Writing 0 to bit 0 clears; status refreshes only on interrupt.
// - Sources are masked after reset; unmasked change drives interrupt low.
package pmis_pkg;

    // ************************************************************
    // addressing
    // ************************************************************
    localparam logic [6:0] OWN_ADDR_DEFAULT = 7'h48;
    localparam logic [4:0] HS_CODE_TOP      = 5'h01;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] REG_STATUS_ONE = 8'h00;
    localparam logic [7:0] REG_MASK_ONE   = 8'h02;
    localparam logic [7:0] READ_UNMAPPED  = 8'hFF;
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [7:0] MASK_RESET     = 8'h00;
    localparam logic [7:0] PTR_RESET      = 8'h00;
    localparam logic [7:0] STICKY_BITS    = 8'hE0;
    localparam logic [7:0] LEVEL_BITS     = 8'h1E;
    localparam logic [7:0] PEND_BIT_MASK  = 8'h01;
    localparam logic [7:0] MASK_WRITABLE  = 8'hFE;
    localparam int         PEND_BIT       = 0;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int         CLK_PERIOD_NS = 50;
    localparam int         SPIKE_NS      = 50;
    localparam int         SPIKE_CYC_I   = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] SPIKE_CYC     = 2'(SPIKE_CYC_I < 1 ? 1 : SPIKE_CYC_I);

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic converter_two_overload;
        logic converter_one_overload;
        logic charge_done_flag;
        logic charge_active_flag;
        logic battery_good_flag;
        logic system_supply_good_flag;
        logic adapter_good_flag;
    } pmis_src_t;

    typedef struct packed {
        logic       first;
        logic [7:0] data;
    } pmis_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SKIP, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
    } pmis_state_t;

endpackage

/* design/pmis_pin_filter.sv */
/*
 * Two-flop synchroniser plus spike filter for one link pin.
 * Assumes the pin is asynchronous to i_clk_sys.
 */
`timescale 1ns/1ps
module pmis_pin_filter (
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    input  wire logic i_pin,
    output logic      o_level
);
    import pmis_pkg::*;

    logic       meta;
    logic       sync;
    logic [1:0] stable_cnt;
    logic       differs;
    logic       accept;

    assign differs = sync ^ o_level;
    assign accept  = differs && (stable_cnt == SPIKE_CYC);

    // idle bus is pulled high, so the filter starts high
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            meta <= 1'b1;
            sync <= 1'b1;
        end else begin
            meta <= i_pin;
            sync <= meta;
        end
    end

    // a change must persist past the spike window to be taken
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            stable_cnt <= 2'h0;
            o_level    <= 1'b1;
        end else begin
            stable_cnt <= (differs && !accept) ? stable_cnt + 2'h1 : 2'h0;
            o_level    <= accept ? sync : o_level;
        end
    end

endmodule

/* tb/pmis_i2c_slave_checker.sv */
/*
 * Checker for the slave port's pin behaviour and interrupt output.
 * Assumes it is bound to pmis_i2c_slave and sees only its ports.
 */
`timescale 1ns/1ps
module pmis_i2c_slave_checker (
    input wire logic                i_clk_sys,
    input wire logic                i_reset,
    input wire logic                i_scl,
    input wire logic                i_sda,
    input wire logic                i_uvlo,
    input wire logic [1:0]          i_addr_opt,
    input wire pmis_pkg::pmis_src_t i_src,
    input wire logic                o_sda_out,
    input wire logic                o_sda_oe,
    input wire logic                o_irq_n,
    input wire logic                o_osc_en,
    input wire logic                o_hs_mode
);
    import pmis_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    // ********************************
    // link conditions
    // ********************************
    sequence s_start;
        i_scl && $fell(i_sda);
    endsequence
    sequence s_stop;
        i_scl && $rose(i_sda);
    endsequence

    a_open_drain: assert property (o_sda_out == 1'b0)
        else $error("sda driven high");
    a_start_wakes: assert property (s_start |-> ##[2:10] o_osc_en)
        else $error("oscillator not started by start");
    a_stop_release: assert property (s_stop |-> ##[1:10] (!o_sda_oe && !o_osc_en))
        else $error("link not released after stop");
    a_oe_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("sda pulled while scl high");
    a_hs_no_ack: assert property ($rose(o_hs_mode) |-> !o_sda_oe [*8])
        else $error("high-speed code acknowledged");
    a_hs_stop_end: assert property (o_hs_mode ##0 s_stop |-> ##[1:10] !o_hs_mode)
        else $error("high-speed mode kept after stop");
    // an interrupt needs a recent source change; mask alone never fires it
    a_irq_cause: assert property ($fell(o_irq_n) |-> $past(i_src, 1) != $past(i_src, 12))
        else $error("interrupt without source change");
    a_irq_holds: assert property (!o_irq_n && !o_osc_en
        && !(i_uvlo || $past(i_uvlo) || $past(i_uvlo, 2) || $past(i_uvlo, 3))
        |=> !o_irq_n)
        else $error("interrupt cleared without bus write");
    a_uvlo_quiet: assert property (i_uvlo [*4] |=> (o_irq_n && !o_sda_oe && !o_osc_en))
        else $error("outputs active in undervoltage");
endmodule

bind pmis_i2c_slave pmis_i2c_slave_checker u_chk (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .i_uvlo     (i_uvlo),
    .i_addr_opt (i_addr_opt),
    .i_src      (i_src),
    .o_sda_out  (o_sda_out),
    .o_sda_oe   (o_sda_oe),
    .o_irq_n    (o_irq_n),
    .o_osc_en   (o_osc_en),
    .o_hs_mode  (o_hs_mode)
);

/* tb/pmis_link_master.sv */
/*
 * Bus master model: drives SCL and pulls SDA low, open drain.
 * Assumes the bench resolves the SDA wire with a pull-up.
 */
`timescale 1ns/1ps
module pmis_link_master (
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda_oe
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end

    // ********************************
    // bus cycles
    // ********************************
    // scl low 400 ns: the port needs that long to present its data
    task automatic start();
        // a repeated start must not cut scl low short of the slave's release
        #100 o_sda_oe = 1'b0;
        #300 o_scl = 1'b1;
        #400 o_sda_oe = 1'b1;
        #400 o_scl = 1'b0;
    endtask
    task automatic stop();
        #100 o_sda_oe = 1'b1;
        #300 o_scl = 1'b1;
        #400 o_sda_oe = 1'b0;
        #400;
    endtask
    task automatic bit_slot(input logic b, output logic got);
        #100 o_sda_oe = ~b;
        #300 o_scl = 1'b1;
        #200 got = i_sda_line;
        #200 o_scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic mack,
                        output logic [7:0] rx, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(tx[i], b);
            rx[i] = b;
        end
        bit_slot(mack, b);
        ack = ~b;
    endtask
endmodule

/* tb/test_pmu_i2c_slave_irq_status.sv */
/*
 * Self-checking bench for the two-wire slave port and status register.
 * Assumes the master model and checker are compiled before it.
 */
`timescale 1ns/1ps
module test_pmu_i2c_slave_irq_status;
    import pmis_pkg::*;
    typedef struct packed {
        logic       wr;
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } pmis_row_t;
    logic       clk, reset, uvlo, scl, m_oe, dut_out, dut_oe, irq_n, osc_en, hs_mode;
    logic [1:0] addr_opt;
    pmis_src_t  src;
    logic [6:0] dev;
    logic [7:0] rx;
    logic       ack;
    logic [7:0] got [3];
    int         n_errors;
    int         check_count;
    pmis_row_t  rows [7];
    logic [7:0] bad [3];
    wire logic  sda_line = !(m_oe || (dut_oe && !dut_out));

    pmis_i2c_slave u_dut (
        .i_clk_sys  (clk),
        .i_reset    (reset),
        .i_scl      (scl),
        .i_sda      (sda_line),
        .i_uvlo     (uvlo),
        .i_addr_opt (addr_opt),
        .i_src      (src),
        .o_sda_out  (dut_out),
        .o_sda_oe   (dut_oe),
        .o_irq_n    (irq_n),
        .o_osc_en   (osc_en),
        .o_hs_mode  (hs_mode)
    );
    pmis_link_master u_master (
        .i_sda_line (sda_line),
        .o_scl      (scl),
        .o_sda_oe   (m_oe)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ********************************
    // tasks
    // ********************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic probe(input logic [7:0] a);
        u_master.start();
        u_master.xfer(a, 1'b1, rx, ack);
        u_master.stop();
    endtask
    task automatic set_ptr(input logic [7:0] ptr);
        u_master.start();
        u_master.xfer({dev, 1'b0}, 1'b1, rx, ack);
        u_master.xfer(ptr, 1'b1, rx, ack);
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        set_ptr(ptr);
        u_master.xfer(d, 1'b1, rx, ack);
        u_master.stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        set_ptr(ptr);
        u_master.start();
        u_master.xfer({dev, 1'b1}, 1'b1, rx, ack);
        for (int i = 0; i < n; i++) begin
            u_master.xfer(8'hFF, 1'(i == n - 1), rx, ack);
            got[i] = rx;
        end
        u_master.stop();
    endtask

    // ********************************
    // sequence
    // ********************************
    initial begin
        n_errors = 0;
        check_count = 0;
        reset = 1'b1;
        uvlo = 1'b0;
        addr_opt = 2'b00;
        src = '0;
        dev = 7'h48;
        rows = '{'{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h02, 8'h00, 8'h00},
                 '{1'b0, 8'h01, 8'h00, 8'hFF}, '{1'b0, 8'h9A, 8'h00, 8'hFF},
                 '{1'b1, 8'h01, 8'h55, 8'hFF}, '{1'b1, 8'h00, 8'hFE, 8'h00},
                 '{1'b1, 8'h02, 8'hFF, 8'hFE}};
        bad = '{8'h92, 8'h00, 8'hF0};
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (10) @(negedge clk);
        check("idle", 8'h01, {4'h0, hs_mode, osc_en, dut_oe, irq_n});
        src = 7'h7F;
        repeat (20) @(negedge clk);
        check("masked", 8'h01, {7'h00, irq_n});
        src = '0;
        repeat (20) @(negedge clk);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].ptr, rows[i].wdata);
            end
            rd(rows[i].ptr, 1);
            check("row", rows[i].exp, got[0]);
        end
        foreach (bad[i]) begin
            probe(bad[i]);
            check("bad_addr", 8'h00, {7'h00, ack});
        end
        probe({dev, 1'b0});
        check("own_addr", 8'h01, {7'h00, ack});
        src = 7'h51;
        repeat (20) @(negedge clk);
        check("irq_set", 8'h00, {7'h00, irq_n});
        rd(8'h00, 1);
        check("status", 8'hA3, got[0]);
        wr(8'h00, 8'h00);
        check("irq_clr", 8'h01, {7'h00, irq_n});
        rd(8'h00, 1);
        check("status", 8'h02, got[0]);
        src = '0;
        repeat (20) @(negedge clk);
        rd(8'h00, 1);
        check("status", 8'h01, got[0]);
        wr(8'h00, 8'h00);
        rd(8'h00, 3);
        check("burst0", 8'h00, got[0]);
        check("burst1", 8'hFF, got[1]);
        check("burst2", 8'hFE, got[2]);
        u_master.start();
        u_master.xfer(8'h0B, 1'b1, rx, ack);
        check("hs_ack", 8'h00, {7'h00, ack});
        check("hs_mode", 8'h01, {7'h00, hs_mode});
        u_master.start();
        u_master.xfer({dev, 1'b0}, 1'b1, rx, ack);
        check("hs_addr", 8'h01, {7'h00, ack});
        u_master.stop();
        check("hs_end", 8'h00, {7'h00, hs_mode});
        uvlo = 1'b1;
        repeat (10) @(negedge clk);
        uvlo = 1'b0;
        repeat (10) @(negedge clk);
        rd(8'h02, 1);
        check("uvlo_mask", 8'h00, got[0]);
        reset = 1'b1;
        addr_opt = 2'b11;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (10) @(negedge clk);
        probe(8'h90);
        check("old_addr", 8'h00, {7'h00, ack});
        dev = 7'h4B;
        probe({dev, 1'b0});
        check("strap_addr", 8'h01, {7'h00, ack});
        stop_test();
    end

    // run needs well under 1 ms; 3 ms means a hang
    initial begin
        #3000000;
        n_errors++;
        stop_test();
    end
endmodule
